// ### logic/pfbp_top.sv
// block copy sequencer between ram and a 16-bit parallel nor flash
// assumes ram_rdata valid the cycle after ram_re is high; requests
// and bus_permit come from ref_clk logic, flash_dq_in from the pins
`timescale 1ns/1ns
module pfbp_top #(
  parameter int RST_CYCLES = pfbp_pkg::RST_CYC,
  parameter int ERASE_CYCLES = pfbp_pkg::ERASE_CYC,
  parameter int PROG_CYCLES = pfbp_pkg::PROG_CYC
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // requester
  input wire logic [15:0] ram_start,
  input wire logic [23:0] flash_start,
  input wire logic [15:0] word_count,
  input wire logic write_req,
  input wire logic read_req,
  output logic busy,
  output logic done,
  output logic error,
  // ram port
  output logic [15:0] ram_addr,
  output logic [31:0] ram_wdata,
  input wire logic [31:0] ram_rdata,
  output logic ram_re,
  output logic ram_we,
  // shared internal bus
  output logic bus_release,
  input wire logic bus_permit,
  // flash pins
  output logic [23:0] flash_addr,
  input wire logic [15:0] flash_dq_in,
  output logic [15:0] flash_dq_out,
  output logic flash_dq_oe,
  output logic flash_ce_n,
  output logic flash_oe_n,
  output logic flash_we_n,
  output logic flash_rst_n,
  output logic address_valid_n,
  output logic sync_read_clock
);
  pfbp_pkg::pfbp_seq_type s_r, s_nxt; // sequencer state
  pfbp_pkg::pfbp_pins_type pins; // flash pins from the engine
  logic start; // open a bus cycle
  logic c_wr; // cycle is a write
  logic op; // current state needs a bus cycle
  logic [23:0] c_addr; // cycle address
  logic [15:0] c_data; // cycle write data
  logic [15:0] cyc_rdata; // last read word
  logic cyc_done; // cycle finished
  logic [25:0] limit; // busy tolerance of this poll

  // base address of the block holding a word
  function automatic logic [23:0] blk(input logic [23:0] a);
    blk = a & pfbp_pkg::BLOCK_MASK;
  endfunction : blk

  // flash words in the next buffer pass
  function automatic logic [5:0] pass_len(input logic [16:0] r);
    pass_len = (r >= 17'(pfbp_pkg::BUF_WORDS)) ? pfbp_pkg::BUF_WORDS : r[5:0];
  endfunction : pass_len

  //////////////////////////////////////////////////////////////////////
  // bus cycle engine
  pfbp_cycle u_cycle (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .start(start),
    .wr(c_wr),
    .addr(c_addr),
    .wdata(c_data),
    .din(s_r.dq_s2),
    .pins(pins),
    .rdata(cyc_rdata),
    .done(cyc_done)
  );

  //////////////////////////////////////////////////////////////////////
  // sequencer next state
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.ram_re = 1'b0;
    s_nxt.ram_we = 1'b0;
    s_nxt.dq_s1 = flash_dq_in;
    s_nxt.dq_s2 = s_r.dq_s1;
    op = 1'b0;
    c_wr = 1'b1;
    c_addr = s_r.fa;
    c_data = 16'h0000;
    start = 1'b0;
    // erase gets seconds, everything else the buffer pass figure
    limit = (s_r.kind == pfbp_pkg::K_ERASE) ? 26'(ERASE_CYCLES) : 26'(PROG_CYCLES);
    case (s_r.st)
      pfbp_pkg::ST_RST: begin
        // hold the flash in reset after power-up
        s_nxt.rst_cnt = s_r.rst_cnt + 16'h0001;
        if (s_r.rst_cnt == 16'(RST_CYCLES - 1)) begin
          s_nxt.flash_rst_n = 1'b1;
          s_nxt.rst_cnt = 16'h0000;
          s_nxt.st = pfbp_pkg::ST_RECOV;
        end
      end
      pfbp_pkg::ST_RECOV: begin
        // quiet time before the first access
        s_nxt.rst_cnt = s_r.rst_cnt + 16'h0001;
        if (s_r.rst_cnt == 16'(pfbp_pkg::RECOV_CYC - 1)) begin
          s_nxt.busy = 1'b0;
          s_nxt.st = pfbp_pkg::ST_IDLE;
        end
      end
      pfbp_pkg::ST_IDLE: begin
        // take a request; write wins if both arrive together
        s_nxt.fa = flash_start;
        s_nxt.ram_addr = ram_start;
        s_nxt.rem = {word_count, 1'b0}; // two flash words each
        if (write_req || read_req) begin
          s_nxt.err = 1'b0;
          s_nxt.busy = 1'b1;
          s_nxt.st = write_req ? pfbp_pkg::ST_UNLK1 : pfbp_pkg::ST_RD_CMD;
        end
      end
      // array read path, default page read mode is left alone
      pfbp_pkg::ST_RD_CMD: begin
        op = 1'b1;
        c_data = pfbp_pkg::CMD_READ_ARRAY;
        if (cyc_done)
          s_nxt.st = (s_r.rem == 17'h0) ? pfbp_pkg::ST_FIN : pfbp_pkg::ST_RD_LO;
      end
      pfbp_pkg::ST_RD_LO, pfbp_pkg::ST_RD_HI: begin
        op = 1'b1;
        c_wr = 1'b0;
        if (cyc_done) begin
          s_nxt.fa = s_r.fa + 24'h000001;
          if (s_r.st == pfbp_pkg::ST_RD_LO) begin
            s_nxt.word[15:0] = cyc_rdata;
            s_nxt.st = pfbp_pkg::ST_RD_HI;
          end else begin
            s_nxt.word[31:16] = cyc_rdata;
            s_nxt.ram_we = 1'b1;
            s_nxt.rem = s_r.rem - 17'h2;
            s_nxt.st = pfbp_pkg::ST_RD_ADV;
          end
        end
      end
      pfbp_pkg::ST_RD_ADV: begin
        s_nxt.ram_addr = s_r.ram_addr + 16'h0001;
        s_nxt.st = (s_r.rem == 17'h0) ? pfbp_pkg::ST_FIN : pfbp_pkg::ST_RD_LO;
      end
      // unlock and erase the target block
      pfbp_pkg::ST_UNLK1, pfbp_pkg::ST_UNLK2, pfbp_pkg::ST_ERS1, pfbp_pkg::ST_ERS2: begin
        op = 1'b1;
        c_addr = blk(s_r.fa);
        case (s_r.st)
          pfbp_pkg::ST_UNLK1: c_data = pfbp_pkg::CMD_LOCK_SETUP;
          pfbp_pkg::ST_ERS1: c_data = pfbp_pkg::CMD_ERASE;
          default: c_data = pfbp_pkg::CMD_CONFIRM;
        endcase
        if (cyc_done) begin
          s_nxt.tmo = 26'h0;
          case (s_r.st)
            pfbp_pkg::ST_UNLK1: s_nxt.st = pfbp_pkg::ST_UNLK2;
            pfbp_pkg::ST_ERS1: s_nxt.st = pfbp_pkg::ST_ERS2;
            pfbp_pkg::ST_UNLK2: begin
              s_nxt.kind = pfbp_pkg::K_UNLOCK;
              s_nxt.st = pfbp_pkg::ST_POLL;
            end
            default: begin
              s_nxt.kind = pfbp_pkg::K_ERASE;
              s_nxt.bus_release = 1'b1;
              s_nxt.st = pfbp_pkg::ST_POLL;
            end
          endcase
        end
      end
      pfbp_pkg::ST_GRANT: begin
        // erase over: take the shared bus back only when permitted
        if (bus_permit) begin
          // a long erase must not eat the first buffer pass budget
          s_nxt.tmo = 26'h0;
          s_nxt.bus_release = 1'b0;
          s_nxt.st = pfbp_pkg::ST_BUF_CMD;
        end
      end
      // buffered program pass
      pfbp_pkg::ST_BUF_CMD: begin
        op = 1'b1;
        c_data = pfbp_pkg::CMD_BUF_PROG;
        if (cyc_done) begin
          s_nxt.pass_base = s_r.fa;
          s_nxt.kind = pfbp_pkg::K_BUF;
          s_nxt.st = pfbp_pkg::ST_POLL;
        end
      end
      pfbp_pkg::ST_BUF_CNT: begin
        op = 1'b1;
        c_data = 16'(pass_len(s_r.rem) - 6'h01);
        if (cyc_done) begin
          s_nxt.pleft = pass_len(s_r.rem);
          s_nxt.st = pfbp_pkg::ST_RAM_RD;
        end
      end
      pfbp_pkg::ST_RAM_RD: begin
        s_nxt.ram_re = 1'b1;
        s_nxt.st = pfbp_pkg::ST_RAM_WAIT;
      end
      pfbp_pkg::ST_RAM_WAIT: s_nxt.st = pfbp_pkg::ST_RAM_LATCH;
      pfbp_pkg::ST_RAM_LATCH: begin
        s_nxt.word = ram_rdata;
        s_nxt.st = pfbp_pkg::ST_WR_LO;
      end
      pfbp_pkg::ST_WR_LO, pfbp_pkg::ST_WR_HI: begin
        // consecutive addresses from the pass start
        op = 1'b1;
        c_data = (s_r.st == pfbp_pkg::ST_WR_LO) ? s_r.word[15:0] : s_r.word[31:16];
        if (cyc_done) begin
          s_nxt.fa = s_r.fa + 24'h000001;
          s_nxt.rem = s_r.rem - 17'h1;
          s_nxt.pleft = s_r.pleft - 6'h01;
          if (s_r.st == pfbp_pkg::ST_WR_LO) begin
            s_nxt.st = pfbp_pkg::ST_WR_HI;
          end else begin
            s_nxt.ram_addr = s_r.ram_addr + 16'h0001;
            s_nxt.st = (s_r.pleft == 6'h01) ? pfbp_pkg::ST_CONF : pfbp_pkg::ST_RAM_RD;
          end
        end
      end
      pfbp_pkg::ST_CONF: begin
        op = 1'b1;
        c_addr = blk(s_r.pass_base);
        c_data = pfbp_pkg::CMD_CONFIRM;
        if (cyc_done) begin
          s_nxt.tmo = 26'h0;
          s_nxt.kind = pfbp_pkg::K_PROG;
          s_nxt.st = pfbp_pkg::ST_POLL;
        end
      end
      pfbp_pkg::ST_POLL: begin
        // status state is entered by the command itself
        op = 1'b1;
        c_wr = 1'b0;
        s_nxt.tmo = s_r.tmo + 26'h1;
        if (cyc_done) begin
          if (!cyc_rdata[pfbp_pkg::READY_BIT]) begin
            // busy: a fresh read retoggles ce and oe next cycle; a buffer pass sends E8 again
            if (s_r.tmo >= limit) begin
              s_nxt.err = 1'b1;
              s_nxt.st = pfbp_pkg::ST_FIN;
            end else if (s_r.kind == pfbp_pkg::K_BUF) begin
              s_nxt.st = pfbp_pkg::ST_BUF_CMD;
            end
          end else if (s_r.kind == pfbp_pkg::K_BUF) begin
            s_nxt.st = pfbp_pkg::ST_BUF_CNT;
          end else if (cyc_rdata[pfbp_pkg::ERASE_ERR_BIT] || cyc_rdata[pfbp_pkg::PROG_ERR_BIT]
                       || cyc_rdata[pfbp_pkg::LOW_VPP_BIT]
                       || cyc_rdata[pfbp_pkg::LOCKED_BIT]) begin
            s_nxt.err = 1'b1;
            s_nxt.st = pfbp_pkg::ST_FIN;
          end else begin
            // each pass starts with a fresh busy budget
            s_nxt.tmo = 26'h0;
            case (s_r.kind)
              pfbp_pkg::K_UNLOCK: s_nxt.st = pfbp_pkg::ST_ERS1;
              pfbp_pkg::K_ERASE: s_nxt.st = pfbp_pkg::ST_GRANT;
              default: s_nxt.st = (s_r.rem == 17'h0) ? pfbp_pkg::ST_FIN : pfbp_pkg::ST_BUF_CMD;
            endcase
          end
        end
      end
      pfbp_pkg::ST_FIN: begin
        s_nxt.done = 1'b1;
        s_nxt.busy = 1'b0;
        s_nxt.bus_release = 1'b0;
        s_nxt.st = pfbp_pkg::ST_IDLE;
      end
      default: s_nxt.st = pfbp_pkg::ST_IDLE;
    endcase
    // one bus cycle at a time; cleared again when it ends
    if (op && !s_r.issued) begin
      start = 1'b1;
      s_nxt.issued = 1'b1;
    end
    if (cyc_done)
      s_nxt.issued = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // state register, frozen while clk_en is low
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.busy <= 1'b1;
      s_r.sclk <= 1'b1;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  // outputs, all from flip-flops
  assign busy = s_r.busy;
  assign done = s_r.done;
  assign error = s_r.err;
  assign ram_addr = s_r.ram_addr;
  assign ram_wdata = s_r.word;
  assign ram_re = s_r.ram_re;
  assign ram_we = s_r.ram_we;
  assign bus_release = s_r.bus_release;
  assign flash_rst_n = s_r.flash_rst_n;
  assign address_valid_n = s_r.adv_n;
  assign sync_read_clock = s_r.sclk;
  assign flash_addr = pins.addr;
  assign flash_dq_out = pins.dout;
  assign flash_dq_oe = pins.dq_oe;
  assign flash_ce_n = pins.ce_n;
  assign flash_oe_n = pins.oe_n;
  assign flash_we_n = pins.we_n;

  //////////////////////////////////////////////////////////////////////
  // checks
  logic [15:0] low_q; // cycles flash reset has been held
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst)
      low_q <= 16'h0000;
    else if (clk_en && !flash_rst_n)
      low_q <= low_q + 16'h0001;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst || !clk_en);

  AST_PINS_TIED: assert property (!address_valid_n && sync_read_clock)
    else $error("address valid or sync clock not tied");
  AST_RST_WIDTH: assert property ($rose(flash_rst_n) |-> low_q >= 16'(RST_CYCLES))
    else $error("flash reset pulse too short");
  AST_RECOVERY: assert property ($rose(flash_rst_n) |-> flash_ce_n [*2])
    else $error("access too soon after flash reset");
  AST_ARRAY_CMD: assert property ((s_r.st == pfbp_pkg::ST_RD_CMD && start) |=>
    (flash_dq_out == 16'h00FF && flash_addr == $past(s_r.fa) && !flash_ce_n))
    else $error("array read command wrong");
  AST_UNLOCK: assert property ((s_r.st == pfbp_pkg::ST_UNLK1 && start) |->
    (c_data == 16'h0060 && c_addr == (s_r.fa & 24'hFF0000)))
    else $error("unlock setup wrong");
  AST_ERASE: assert property ((s_r.st == pfbp_pkg::ST_ERS1 && start) |->
    (c_data == 16'h0020 && c_addr == (s_r.fa & 24'hFF0000)))
    else $error("erase setup wrong");
  AST_BUF_CMD: assert property ((s_r.st == pfbp_pkg::ST_BUF_CMD && start) |->
    (c_data == 16'h00E8 && c_addr == s_r.fa))
    else $error("buffer program command wrong");
  AST_COUNT: assert property ((s_r.st == pfbp_pkg::ST_BUF_CNT && start) |->
    (c_data <= 16'h001F && c_data[0]))
    else $error("buffer count out of range");
  AST_RELEASE: assert property ((s_r.st == pfbp_pkg::ST_POLL
    && s_r.kind == pfbp_pkg::K_ERASE) |-> bus_release)
    else $error("shared bus held during erase");
  AST_REPOLL: assert property ((s_r.st == pfbp_pkg::ST_POLL && cyc_done
    && !cyc_rdata[7] && s_r.kind != pfbp_pkg::K_BUF) |->
    flash_oe_n ##1 (start || s_r.st == pfbp_pkg::ST_FIN))
    else $error("busy status not re-read");
  AST_ERR_DONE: assert property ((s_r.st == pfbp_pkg::ST_POLL && cyc_done
    && cyc_rdata[7] && s_r.kind != pfbp_pkg::K_BUF && (|cyc_rdata[5:4] || cyc_rdata[3]
    || cyc_rdata[1])) |=> ##1 (done && error))
    else $error("error status not reported");
  AST_DONE_PULSE: assert property (done |-> !busy ##1 !done)
    else $error("done is not a single pulse");

  COV_READ: cover property (s_r.st == pfbp_pkg::ST_RD_ADV ##[1:20] done);
  COV_WRITE: cover property (s_r.st == pfbp_pkg::ST_CONF ##[1:1000] (done && !error));
  COV_GRANT: cover property (bus_release && bus_permit);
  COV_ERROR: cover property (done && error);
endmodule : pfbp_top

// ### logic/pfbp_pkg.sv
// constants, states and carriers for the parallel flash block programmer
// assumes a 10 MHz logic clock and a 16-bit asynchronous nor flash
package pfbp_pkg;
  // clock rate
  localparam int CLK_MHZ = 10;
  // flash reset pulse and recovery after it
  localparam int RST_US = 500;
  localparam int RST_CYC = RST_US * CLK_MHZ;
  localparam int RECOV_NS = 150;
  localparam int RECOV_CYC = (RECOV_NS * CLK_MHZ + 999) / 1000;
  // address to data access time, plus the pin synchroniser
  localparam int ACCESS_NS = 95;
  localparam int ACCESS_CYC = (ACCESS_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_STAGES = 2;
  localparam logic [2:0] RD_HOLD = 3'(ACCESS_CYC + SYNC_STAGES + 1);
  // busy tolerances
  localparam int ERASE_S = 4;
  localparam int ERASE_CYC = ERASE_S * CLK_MHZ * 1000000;
  localparam int PROG_US = 880;
  localparam int PROG_CYC = PROG_US * CLK_MHZ;
  // write buffer size in flash words
  localparam logic [5:0] BUF_WORDS = 6'h20;
  // command codes
  localparam logic [15:0] CMD_READ_ARRAY = 16'h00FF;
  localparam logic [15:0] CMD_LOCK_SETUP = 16'h0060;
  localparam logic [15:0] CMD_CONFIRM = 16'h00D0;
  localparam logic [15:0] CMD_ERASE = 16'h0020;
  localparam logic [15:0] CMD_BUF_PROG = 16'h00E8;
  // memory_status_word bit positions
  localparam int READY_BIT = 7;
  localparam int ERASE_ERR_BIT = 5;
  localparam int PROG_ERR_BIT = 4;
  localparam int LOW_VPP_BIT = 3;
  localparam int LOCKED_BIT = 1;
  // one 64k-word block
  localparam logic [23:0] BLOCK_MASK = 24'hFF0000;

  typedef enum logic [4:0] {
    ST_RST, ST_RECOV, ST_IDLE, ST_RD_CMD, ST_RD_LO, ST_RD_HI, ST_RD_ADV,
    ST_UNLK1, ST_UNLK2, ST_ERS1, ST_ERS2, ST_GRANT, ST_BUF_CMD, ST_BUF_CNT,
    ST_RAM_RD, ST_RAM_WAIT, ST_RAM_LATCH, ST_WR_LO, ST_WR_HI, ST_CONF,
    ST_POLL, ST_FIN
  } pfbp_state_type;

  typedef enum logic [1:0] {K_UNLOCK, K_ERASE, K_BUF, K_PROG} pfbp_kind_type;

  // flash pin bundle
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic [23:0] addr;
    logic [15:0] dout;
  } pfbp_pins_type;

  // bus cycle engine state
  typedef struct packed {
    logic busy;
    logic wr;
    logic [2:0] cnt;
    pfbp_pins_type pins;
    logic [15:0] rdata;
    logic done;
  } pfbp_cyc_type;

  // sequencer state
  typedef struct packed {
    pfbp_state_type st;
    pfbp_kind_type kind;
    logic issued;
    logic [15:0] rst_cnt;
    logic [25:0] tmo;
    logic [23:0] fa;
    logic [23:0] pass_base;
    logic [16:0] rem;
    logic [5:0] pleft;
    logic [31:0] word;
    logic [15:0] ram_addr;
    logic ram_re;
    logic ram_we;
    logic done;
    logic err;
    logic busy;
    logic bus_release;
    logic flash_rst_n;
    logic adv_n;
    logic sclk;
    logic [15:0] dq_s1;
    logic [15:0] dq_s2;
  } pfbp_seq_type;
endpackage : pfbp_pkg

// ### logic/pfbp_cycle.sv
// one asynchronous flash read or write cycle
// assumes din is already synchronised to ref_clk
`timescale 1ns/1ns
module pfbp_cycle (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // cycle request
  input wire logic start,
  input wire logic wr,
  input wire logic [23:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] din,
  // results
  output pfbp_pkg::pfbp_pins_type pins,
  output logic [15:0] rdata,
  output logic done
);
  pfbp_pkg::pfbp_cyc_type s_r, s_nxt; // engine state

  //////////////////////////////////////////////////////////////////////
  // next state: ce and oe fall together so each read refreshes status
  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (!s_r.busy) begin
      // idle: a start opens the cycle with chip enable low
      if (start) begin
        s_nxt.busy = 1'b1;
        s_nxt.wr = wr;
        s_nxt.cnt = 3'h0;
        s_nxt.pins.addr = addr;
        s_nxt.pins.dout = wdata;
        s_nxt.pins.ce_n = 1'b0;
        s_nxt.pins.oe_n = wr;
        s_nxt.pins.dq_oe = wr;
      end
    end else begin
      s_nxt.cnt = s_r.cnt + 3'h1;
      if (s_r.wr) begin
        // write: setup, one strobe cycle, then release with hold
        case (s_r.cnt)
          3'h0: s_nxt.pins.we_n = 1'b0;
          3'h1: s_nxt.pins.we_n = 1'b1;
          default: begin
            s_nxt.pins.ce_n = 1'b1;
            s_nxt.pins.dq_oe = 1'b0;
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
          end
        endcase
      end else if (s_r.cnt == pfbp_pkg::RD_HOLD) begin
        // read: access time plus synchroniser delay has passed
        s_nxt.rdata = din;
        s_nxt.pins.ce_n = 1'b1;
        s_nxt.pins.oe_n = 1'b1;
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // state register, frozen while clk_en is low
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
      s_r.pins.ce_n <= 1'b1;
      s_r.pins.oe_n <= 1'b1;
      s_r.pins.we_n <= 1'b1;
    end else if (clk_en) begin
      s_r <= s_nxt;
    end
  end

  assign pins = s_r.pins;
  assign rdata = s_r.rdata;
  assign done = s_r.done;
endmodule : pfbp_cycle

// ### testbench/pfbp_flash_model.sv
// behavioural 16-bit asynchronous nor flash facing the programmer
// assumes the bench resolves the shared data wire from the programmer's output enable
`timescale 1ns/1ns
module pfbp_flash_model (
  // flash pins
  input wire logic [23:0] addr,
  input wire logic [15:0] dq_in,
  output logic [15:0] dq_out,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic rst_n,
  // error bits forced into ready status
  input wire logic [7:0] err_bits
);
  logic [15:0] mem [int]; // programmed words, absent reads as erased
  logic [15:0] val = 16'hFFFF; // last word put on dq
  logic stat = 1'b0; // status read state
  logic unlocked = 1'b0; // blocks come up locked
  logic [23:0] ulk_a = 24'h0; // unlock target address
  logic [15:0] nlog [$]; // buffer counts seen
  logic [23:0] clog [$]; // buffer confirm addresses
  int busy = 0; // status reads still busy
  int phase = 0; // 1 count, 2 data, 3 confirm
  int left = 0; // buffer words still due
  int pend = 0; // 1 lock setup, 2 erase setup
  int viol = 0; // accesses while held in reset
  int e8n = 0; // buffer program commands seen
  wire en_n = ce_n | oe_n;
  // no pull-ups: a released bus shows the inverse, not the old value
  assign dq_out = en_n ? ~val : val;
  ////////////////////////////////////////////////////////////////
  // reads: status refreshes on each falling edge of the combined ce and oe enable
  always @(negedge en_n) begin
    if (!rst_n) viol++;
    if (stat) begin
      val = (busy > 0) ? 16'h0000 : {8'h00, 8'h80 | err_bits};
      if (busy > 0) busy--;
    end else begin
      val = mem.exists(int'(addr)) ? mem[int'(addr)] : 16'hFFFF;
    end
  end
  ////////////////////////////////////////////////////////////////
  // writes: command port and write buffer
  always @(posedge we_n) if (!ce_n) begin
    if (!rst_n) viol++;
    if (phase == 1) begin
      nlog.push_back(dq_in);
      left = int'(dq_in) + 1;
      phase = 2;
    end else if (phase == 2) begin
      if (unlocked) mem[int'(addr)] = dq_in;
      left--;
      if (left == 0) phase = 3;
    end else if (phase == 3) begin
      clog.push_back(addr);
      busy = 3; // quick, well inside the tolerance
      phase = 0;
    end else begin
      case (dq_in)
        16'h00FF: stat = 1'b0;
        16'h0060: pend = 1;
        16'h0020: pend = 2;
        16'h00E8: begin
          // the very first request finds the buffer busy once
          stat = 1'b1;
          e8n++;
          if (e8n == 1) busy = 1;
          else phase = 1;
        end
        16'h00D0: begin
          if (pend == 1) unlocked = 1'b1;
          if (pend == 1) ulk_a = addr;
          if (pend == 2 && unlocked) mem.delete();
          busy = 3;
          stat = 1'b1;
          pend = 0;
        end
        default: stat = 1'b1;
      endcase
    end
  end
endmodule : pfbp_flash_model

// ### testbench/pfbp_top_tb.sv
// self-checking bench for the flash block programmer
// assumes the flash model beside it and a small ram kept here
`timescale 1ns/1ns
module pfbp_top_tb;
  logic ref_clk = 1'b0, nrst = 1'b0, write_req = 1'b0, read_req = 1'b0;
  logic bus_permit = 1'b0, clk_en = 1'b1;
  logic [15:0] ram_start = 16'h0, word_count = 16'h0, ram_addr, flash_dq_out;
  logic [23:0] flash_start = 24'h0, flash_addr;
  logic [31:0] ram_rdata = 32'h0, ram_wdata;
  logic [31:0] ram [64];
  logic [7:0] err_bits = 8'h00;
  logic busy, done, error, ram_re, ram_we, bus_release, flash_dq_oe, flash_ce_n;
  logic flash_oe_n, flash_we_n, flash_rst_n, address_valid_n, sync_read_clock;
  logic [15:0] mdq;
  int err_total = 0, checks_done = 0, cyc = 0, rel_cnt = 0, rel_max = 0;
  wire [15:0] dq = flash_dq_oe ? flash_dq_out : mdq; // resolved data wire
  initial forever #50 ref_clk = ~ref_clk;
  pfbp_top #(.RST_CYCLES(8), .ERASE_CYCLES(200), .PROG_CYCLES(200)) pfbp_top_i (
    .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .ram_start(ram_start),
    .flash_start(flash_start), .word_count(word_count), .write_req(write_req),
    .read_req(read_req), .busy(busy), .done(done), .error(error), .ram_addr(ram_addr),
    .ram_wdata(ram_wdata), .ram_rdata(ram_rdata), .ram_re(ram_re), .ram_we(ram_we),
    .bus_release(bus_release), .bus_permit(bus_permit), .flash_addr(flash_addr),
    .flash_dq_in(dq), .flash_dq_out(flash_dq_out), .flash_dq_oe(flash_dq_oe),
    .flash_ce_n(flash_ce_n), .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n),
    .flash_rst_n(flash_rst_n), .address_valid_n(address_valid_n),
    .sync_read_clock(sync_read_clock));
  pfbp_flash_model pfbp_flash_model_i (.addr(flash_addr), .dq_in(dq), .dq_out(mdq),
    .ce_n(flash_ce_n), .oe_n(flash_oe_n), .we_n(flash_we_n), .rst_n(flash_rst_n),
    .err_bits(err_bits));
  ////////////////////////////////////////////////////////////////
  // ram: data ready the cycle after the read pulse
  always @(posedge ref_clk) begin
    if (ram_we) ram[ram_addr[5:0]] <= ram_wdata;
    if (ram_re) ram_rdata <= ram[ram_addr[5:0]];
  end
  // permit granted late so the release must be held; timeout guard
  always @(negedge ref_clk) begin
    rel_cnt = bus_release ? rel_cnt + 1 : 0;
    if (rel_cnt > rel_max) rel_max = rel_cnt;
    bus_permit = (rel_cnt >= 40);
    cyc++;
    // freeze one cycle now and then mid-read; data must still arrive intact
    clk_en = !(flash_oe_n === 1'b0 && cyc % 50 == 0);
    if (cyc == 40000) begin
      err_total++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] word_of(input int i);
    return 32'hA5000000 + 32'(i) * 32'h00010203;
  endfunction : word_of
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic run_op(input logic wr, input logic [15:0] rs, input logic [23:0] fs,
      input logic [15:0] n);
    int t;
    t = 0;
    ram_start = rs;
    flash_start = fs;
    word_count = n;
    write_req = wr;
    read_req = !wr;
    @(negedge ref_clk);
    write_req = 1'b0;
    read_req = 1'b0;
    while (done !== 1'b1 && t < 20000) begin
      @(negedge ref_clk);
      t++;
    end
    chk(32'(t < 20000), 32'h1);
  endtask : run_op
  ////////////////////////////////////////////////////////////////
  // reset: flash held in reset, then quiet before the first access
  task automatic sc_reset;
    int low;
    low = 0;
    repeat (20) @(negedge ref_clk);
    chk(flash_rst_n, 1'b0);
    chk(busy, 1'b1);
    nrst = 1'b1;
    while (busy !== 1'b0 && low < 200) begin
      if (flash_rst_n === 1'b0) low++;
      @(negedge ref_clk);
    end
    chk(32'(low >= 8), 32'h1);
    chk(flash_rst_n, 1'b1);
  endtask : sc_reset
  // 17 words: one full buffer pass and a two-word pass
  task automatic sc_write;
    for (int i = 0; i < 17; i++) ram[i] = word_of(i);
    run_op(1'b1, 16'h0000, 24'h0A0010, 16'h0011);
    chk(error, 1'b0);
    chk(pfbp_flash_model_i.ulk_a, 24'h0A0000);
    chk(pfbp_flash_model_i.nlog.size(), 2);
    chk(pfbp_flash_model_i.e8n, 3);
    chk(pfbp_flash_model_i.nlog[0], 16'h001F);
    chk(pfbp_flash_model_i.nlog[1], 16'h0001);
    chk(pfbp_flash_model_i.clog[1], 24'h0A0000);
    chk(32'(rel_max >= 40), 32'h1);
    chk(bus_release, 1'b0);
    for (int i = 0; i < 17; i++) begin
      chk(pfbp_flash_model_i.mem[32'h0A0010 + 2 * i], word_of(i) & 32'hFFFF);
      chk(pfbp_flash_model_i.mem[32'h0A0011 + 2 * i], word_of(i) >> 16);
    end
  endtask : sc_write
  // read back: status state left over must be cleared first
  task automatic sc_read;
    for (int i = 32; i < 49; i++) ram[i] = 32'h0;
    run_op(1'b0, 16'h0020, 24'h0A0010, 16'h0011);
    for (int i = 0; i < 17; i++) chk(ram[32 + i], word_of(i));
  endtask : sc_read
  // locked-block report in ready status ends the operation with error
  task automatic sc_error;
    err_bits = 8'h02;
    run_op(1'b1, 16'h0000, 24'h0A0100, 16'h0001);
    chk(error, 1'b1);
    err_bits = 8'h00;
  endtask : sc_error
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  initial begin
    sc_reset();
    sc_write();
    sc_read();
    sc_error();
    chk(pfbp_flash_model_i.viol, 0);
    chk({address_valid_n, sync_read_clock}, 2'b01);
    wrap_up();
  end
endmodule : pfbp_top_tb
